/* File: shared/pmc_pkg.sv */
// constants, field layout and types of the power monitor control block
package pmc_pkg;

  // register word offsets (byte addresses, low bits of haddr)
  localparam int                ADDR_W       = 4;
  localparam logic [ADDR_W-1:0] OFS_DETECT   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_WARN     = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hc;

  // power_detect_control fields
  localparam int B_DET_FLAG  = 7;
  localparam int B_DET_ACK   = 6;
  localparam int B_IRQ_EN    = 5;
  localparam int B_RST_EN    = 4;
  localparam int B_STOP_EN   = 3;
  localparam int B_DET_EN    = 2;

  // power_warning_stop_control fields
  localparam int B_WARN_FLAG = 7;
  localparam int B_WARN_ACK  = 6;
  localparam int B_DET_SEL   = 5;
  localparam int B_WARN_SEL  = 4;
  localparam int B_PPD_FLAG  = 3;
  localparam int B_PPD_ACK   = 2;
  localparam int B_PD_EN     = 1;
  localparam int B_PD_MODE   = 0;

  // values after reset
  localparam logic [7:0] RST_DETECT_CTRL = 8'h1c;
  localparam logic [7:0] RST_WARN_CTRL   = 8'h00;

  // interrupt status and mask layout
  localparam int         IRQ_N        = 3;
  localparam int         IRQ_DETECT   = 0;
  localparam int         IRQ_WARNING  = 1;
  localparam int         IRQ_RECOVERY = 2;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // synchroniser input lanes
  localparam int SYN_DET  = 0;
  localparam int SYN_WARN = 1;
  localparam int SYN_WAKE = 2;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_STOP = 4'b0010,
    ST_FULL = 4'b0100,
    ST_PART = 4'b1000
  } pmc_stop_t;

endpackage : pmc_pkg

/* File: hdl/pmc_sync.sv */
// two-flop synchroniser for comparator and wake levels
`timescale 1ns/10ps
module pmc_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pmc_sync_state_t;

  pmc_sync_state_t q;
  pmc_sync_state_t d;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("pmc_sync needs at least one lane");
    end
  endgenerate

  always_comb begin
    d    = q;
    d.s1 = async;
    d.s2 = q.s1;
    if (!rst_n) begin
      d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign synced = q.s2;

endmodule : pmc_sync

/* File: hdl/pmc_ahb_front.sv */
// ahb-lite address phase capture for the power monitor registers
`timescale 1ns/10ps
module pmc_ahb_front import pmc_pkg::*; (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // address phase
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] addrLow,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  // decoded
  output logic                   rdNow,
  output logic                   wrStb,
  output logic [ADDR_W-1:0]      wAddr
);

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
  } pmc_front_state_t;

  pmc_front_state_t q;
  pmc_front_state_t d;
  logic             take;

  // other sizes are dropped: only whole words are served
  assign take  = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
  assign rdNow = take && !hwrite;

  always_comb begin
    d      = q;
    d.wr   = take && hwrite;
    d.addr = addrLow;
    if (!rst_n) begin
      d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign wrStb = q.wr;
  assign wAddr = q.addr;

endmodule : pmc_ahb_front

/* File: hdl/pmc_power_monitor.sv */
// power monitor control: undervolt detect, warning and power-down stop control
`timescale 1ns/10ps
module pmc_power_monitor import pmc_pkg::*; (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        resetIsPor,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // comparators and power control
  input  wire logic        detectCmp,
  input  wire logic        warningCmp,
  input  wire logic        wakeIn,
  input  wire logic        stopReq,
  output logic             detectActive,
  output logic             detectThresholdSel,
  output logic             warningThresholdSel,
  output logic             fullPowerdownStop,
  output logic             partialPowerdownStop,
  output logic             undervoltIrq,
  output logic             sysResetReq,
  output logic             irq
);

  typedef struct packed {
    logic             detFlag;
    logic             irqEn;
    logic             rstEn;
    logic             stopEn;
    logic             detEn;
    logic             once1;
    logic             warnFlag;
    logic             detSel;
    logic             warnSel;
    logic             ppdFlag;
    logic             pdEn;
    logic             pdMode;
    logic             once2;
    pmc_stop_t        st;
    logic [IRQ_N-1:0] stat;
    logic [IRQ_N-1:0] mask;
    logic [31:0]      rdata;
    logic             detAct;
    logic             detIrq;
    logic             rstReq;
    logic             fullOut;
    logic             partOut;
    logic             irqOut;
    logic             ready;
  } pmc_state_t;

  pmc_state_t        q;
  pmc_state_t        d;
  logic [IRQ_N-1:0]  syn;
  logic              rdNow;
  logic              wrStb;
  logic [ADDR_W-1:0] wAddr;
  logic              wr1;
  logic              wr2;
  logic              wrS;
  logic              wrM;
  logic              detLive;
  logic              wakePart;
  logic [IRQ_N-1:0]  events;

  pmc_sync #(
    .WIDTH (IRQ_N)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async    ({wakeIn, warningCmp, detectCmp}),
    .synced   (syn)
  );

  pmc_ahb_front u_front (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .hsel     (hsel),
    .addrLow  (haddr[ADDR_W-1:0]),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .hsize    (hsize),
    .hready   (hready),
    .rdNow    (rdNow),
    .wrStb    (wrStb),
    .wAddr    (wAddr)
  );

  assign wr1 = wrStb && wAddr == OFS_DETECT;
  assign wr2 = wrStb && wAddr == OFS_WARN;
  assign wrS = wrStb && wAddr == OFS_IRQ_STAT;
  assign wrM = wrStb && wAddr == OFS_IRQ_MASK;

  // detection is live in run, and in any stop only if kept on
  assign detLive  = q.detEn && (q.st == ST_RUN || q.stopEn);
  assign wakePart = q.st == ST_PART && syn[SYN_WAKE];

  // events fire on the rising of each flag only
  assign events[IRQ_DETECT]   = detLive && syn[SYN_DET] && !q.detFlag;
  assign events[IRQ_WARNING]  = syn[SYN_WARN] && !q.warnFlag;
  assign events[IRQ_RECOVERY] = wakePart && !q.ppdFlag;

  always_comb begin
    d = q;
    // set wins over the acknowledge in the same cycle
    d.detFlag = (detLive && syn[SYN_DET])
              || (q.detFlag && !(wr1 && hwdata[B_DET_ACK]));
    d.warnFlag = syn[SYN_WARN]
               || (q.warnFlag && !(wr2 && hwdata[B_WARN_ACK]));
    d.ppdFlag = wakePart
              || (q.ppdFlag && !(wr2 && hwdata[B_PPD_ACK]));
    if (wr1) begin
      d.irqEn = hwdata[B_IRQ_EN];
      d.once1 = 1'b1;
      if (!q.once1) begin
        d.rstEn  = hwdata[B_RST_EN];
        d.stopEn = hwdata[B_STOP_EN];
        d.detEn  = hwdata[B_DET_EN];
      end
    end
    if (wr2) begin
      d.detSel  = hwdata[B_DET_SEL];
      d.warnSel = hwdata[B_WARN_SEL];
      d.once2   = 1'b1;
      if (!q.once2) begin
        d.pdEn   = hwdata[B_PD_EN];
        d.pdMode = hwdata[B_PD_MODE];
      end
    end
    unique case (q.st)
      ST_RUN: begin
        if (stopReq) begin
          if (!q.pdEn) begin
            d.st = ST_STOP;
          end else if (q.pdMode) begin
            d.st = ST_PART;
          end else begin
            d.st = ST_FULL;
          end
        end
      end
      ST_STOP, ST_FULL, ST_PART: begin
        if (syn[SYN_WAKE]) begin
          d.st = ST_RUN;
        end
      end
      default: begin
        d.st = ST_RUN;
      end
    endcase
    // write one to clear; a fresh event survives its own clear
    d.stat = (q.stat & ~(wrS ? hwdata[IRQ_N-1:0] : '0)) | events;
    if (wrM) begin
      d.mask = hwdata[IRQ_N-1:0];
    end
    if (!rst_n) begin
      d.detFlag  = RST_DETECT_CTRL[B_DET_FLAG];
      d.irqEn    = RST_DETECT_CTRL[B_IRQ_EN];
      d.rstEn    = RST_DETECT_CTRL[B_RST_EN];
      d.stopEn   = RST_DETECT_CTRL[B_STOP_EN];
      d.detEn    = RST_DETECT_CTRL[B_DET_EN];
      d.once1    = 1'b0;
      d.warnFlag = RST_WARN_CTRL[B_WARN_FLAG];
      d.ppdFlag  = RST_WARN_CTRL[B_PPD_FLAG];
      d.pdEn     = RST_WARN_CTRL[B_PD_EN];
      d.pdMode   = RST_WARN_CTRL[B_PD_MODE];
      d.once2    = 1'b0;
      d.st       = ST_RUN;
      d.stat     = '0;
      d.mask     = RST_IRQ_MASK;
      // selects survive every reset but power-on
      if (resetIsPor) begin
        d.detSel  = RST_WARN_CTRL[B_DET_SEL];
        d.warnSel = RST_WARN_CTRL[B_WARN_SEL];
      end else begin
        d.detSel  = q.detSel;
        d.warnSel = q.warnSel;
      end
    end
    // outputs registered from the next state so they match the fields
    d.detAct = d.detEn && (d.st == ST_RUN || d.stopEn);
    d.detIrq = d.detEn && d.irqEn && d.detFlag;
    d.rstReq = d.detEn && d.rstEn && d.detFlag;
    d.irqOut = |(d.stat & d.mask);
    d.fullOut = d.st == ST_FULL;
    d.partOut = d.st == ST_PART;
    d.ready  = rst_n;
    // read data taken in the address phase from the next state, so a
    // write in the data phase just ending is already visible
    d.rdata = '0;
    if (rdNow && rst_n) begin
      unique case (haddr[ADDR_W-1:0])
        OFS_DETECT:
          d.rdata[7:0] = {d.detFlag, 1'b0, d.irqEn, d.rstEn,
                          d.stopEn, d.detEn, 2'b00};
        OFS_WARN:
          d.rdata[7:0] = {d.warnFlag, 1'b0, d.detSel, d.warnSel,
                          d.ppdFlag, 1'b0, d.pdEn, d.pdMode};
        OFS_IRQ_STAT:
          d.rdata[IRQ_N-1:0] = d.stat;
        OFS_IRQ_MASK:
          d.rdata[IRQ_N-1:0] = d.mask;
        default:
          d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign hrdata               = q.rdata;
  assign hreadyout            = q.ready;
  assign hresp                = 1'b0;
  assign detectActive         = q.detAct;
  assign detectThresholdSel   = q.detSel;
  assign warningThresholdSel  = q.warnSel;
  assign fullPowerdownStop    = q.fullOut;
  assign partialPowerdownStop = q.partOut;
  assign undervoltIrq         = q.detIrq;
  assign sysResetReq          = q.rstReq;
  assign irq                  = q.irqOut;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_stop_part;
    q.st == ST_RUN && stopReq && q.pdEn && q.pdMode;
  endsequence

  sequence s_wake_part;
    q.st == ST_PART && syn[SYN_WAKE];
  endsequence

  property p_det_set;
    detLive && syn[SYN_DET] |=> q.detFlag && undervoltIrq == (q.irqEn && q.detEn);
  endproperty
  a_det_set: assert property (p_det_set) else $error("detect flag missed");

  property p_det_ack;
    wr1 && hwdata[B_DET_ACK] && !(detLive && syn[SYN_DET]) |=> !q.detFlag;
  endproperty
  a_det_ack: assert property (p_det_ack) else $error("detect ack failed");

  property p_det_irq;
    q.detEn && q.irqEn && q.detFlag && $stable(q.detFlag) |-> undervoltIrq;
  endproperty
  a_det_irq: assert property (p_det_irq) else $error("detect irq missing");

  property p_det_rst;
    sysResetReq |-> q.rstEn && q.detEn && q.detFlag;
  endproperty
  a_det_rst: assert property (p_det_rst) else $error("reset without cause");

  property p_stop_off;
    q.st != ST_RUN && !q.stopEn && !q.detFlag |=> !q.detFlag;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("detect ran in stop");

  property p_det_gate;
    !q.detEn && !q.detFlag |=> !q.detFlag && !sysResetReq;
  endproperty
  a_det_gate: assert property (p_det_gate) else $error("disabled detect fired");

  property p_once1;
    wr1 && q.once1 |=> $stable({q.rstEn, q.stopEn, q.detEn});
  endproperty
  a_once1: assert property (p_once1) else $error("second write took effect");

  property p_warn;
    syn[SYN_WARN] |=> q.warnFlag;
  endproperty
  a_warn: assert property (p_warn) else $error("warning flag missed");

  property p_warn_ack;
    wr2 && hwdata[B_WARN_ACK] && !syn[SYN_WARN] |=> !q.warnFlag;
  endproperty
  a_warn_ack: assert property (p_warn_ack) else $error("warning ack failed");

  property p_sel;
    wr2 |=> detectThresholdSel == $past(hwdata[B_DET_SEL])
         && warningThresholdSel == $past(hwdata[B_WARN_SEL]);
  endproperty
  a_sel: assert property (p_sel) else $error("threshold select lost");

  property p_recover;
    s_wake_part |=> q.ppdFlag && q.st == ST_RUN;
  endproperty
  a_recover: assert property (p_recover) else $error("recovery flag missed");

  property p_part_cycle;
    s_stop_part |=> partialPowerdownStop && !fullPowerdownStop;
  endproperty
  a_part_cycle: assert property (p_part_cycle) else $error("partial stop cycle broken");

  property p_pd_block;
    q.st == ST_RUN && stopReq && !q.pdEn |=> !fullPowerdownStop && !partialPowerdownStop;
  endproperty
  a_pd_block: assert property (p_pd_block) else $error("power-down not gated");

  property p_full_entry;
    q.st == ST_RUN && stopReq && q.pdEn && !q.pdMode
      |=> fullPowerdownStop && !partialPowerdownStop;
  endproperty
  a_full_entry: assert property (p_full_entry) else $error("full stop not entered");

  property p_ppd_ack;
    wr2 && hwdata[B_PPD_ACK] && !wakePart |=> !q.ppdFlag;
  endproperty
  a_ppd_ack: assert property (p_ppd_ack) else $error("recovery ack failed");

  // must not be masked by reset: it watches the reset itself
  property p_sel_keep;
    disable iff (1'b0) !rst_n && !resetIsPor |=> $stable({q.detSel, q.warnSel});
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("selects lost in reset");

  property p_rd_zero;
    rdNow && haddr[ADDR_W-1:0] == OFS_WARN |=> !hrdata[B_WARN_ACK] && !hrdata[B_PPD_ACK];
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("ack bit read back");

endmodule : pmc_power_monitor

/* File: tb/testbench.sv */
// self-checking testbench for the power monitor control block
`timescale 1ns/10ps
module testbench import pmc_pkg::*;;
  // clock, reset and bus side
  logic        core_clk   = 1'b0;
  logic        rst_n      = 1'b0;
  logic        resetIsPor = 1'b1;
  logic        hsel       = 1'b1;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [2:0]  hsize      = 3'h2;
  logic [31:0] hwdata     = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  // power side
  logic        detectCmp  = 1'b0;
  logic        warningCmp = 1'b0;
  logic        wakeIn     = 1'b0;
  logic        stopReq    = 1'b0;
  logic        detActive;
  logic        detSel;
  logic        warnSel;
  logic        fullStop;
  logic        partStop;
  logic        uvIrq;
  logic        sysRst;
  logic        irq;
  int          failures   = 0;
  int          compares   = 0;

  always #10 core_clk = ~core_clk;

  pmc_power_monitor i_dut (
    .core_clk            (core_clk),
    .rst_n               (rst_n),
    .resetIsPor          (resetIsPor),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hready),
    .hrdata              (hrdata),
    .hreadyout           (hready),
    .hresp               (hresp),
    .detectCmp           (detectCmp),
    .warningCmp          (warningCmp),
    .wakeIn              (wakeIn),
    .stopReq             (stopReq),
    .detectActive        (detActive),
    .detectThresholdSel  (detSel),
    .warningThresholdSel (warnSel),
    .fullPowerdownStop   (fullStop),
    .partialPowerdownStop(partStop),
    .undervoltIrq        (uvIrq),
    .sysResetReq         (sysRst),
    .irq                 (irq)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // both phases wait on hready, so a wait state would still be honoured
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    haddr  <= {28'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b1;
    hsize  <= HSIZE_WORD;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
  endtask : bus_write

  task automatic read_check(input logic [3:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    haddr  <= {28'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b0;
    hsize  <= HSIZE_WORD;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    do @(posedge core_clk); while (hready !== 1'b1);
    d = hrdata;
    check(what, d, exp);
  endtask : read_check

  task automatic apply_reset(input logic por);
    rst_n      <= 1'b0;
    resetIsPor <= por;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : apply_reset

  // pins are looked at mid-cycle, after the launching edge has landed
  task automatic to_neg();
    @(negedge core_clk);
  endtask : to_neg

  task automatic to_pos();
    @(posedge core_clk);
  endtask : to_pos

  // enter stop, check the mode pins, then wake and let the synchroniser drain
  task automatic do_stop(input logic expFull, input logic expPart, input logic expDet);
    stopReq <= 1'b1;
    @(posedge core_clk);
    stopReq <= 1'b0;
    to_neg();
    check("full stop", fullStop, expFull);
    check("partial stop", partStop, expPart);
    check("detect active in stop", detActive, expDet);
    to_pos();
    wakeIn <= 1'b1;
    repeat (4) @(posedge core_clk);
    wakeIn <= 1'b0;
    repeat (3) @(posedge core_clk);
    to_neg();
    check("back in run", {fullStop, partStop}, 2'b00);
    to_pos();
  endtask : do_stop

  task automatic t_reset_values();
    read_check(OFS_DETECT, {24'h0, RST_DETECT_CTRL}, "detect reg");
    read_check(OFS_WARN, {24'h0, RST_WARN_CTRL}, "warning reg");
    read_check(OFS_IRQ_MASK, 32'h0, "irq mask");
    check("okay response", hresp, 1'b0);
  endtask : t_reset_values

  task automatic t_detect();
    detectCmp <= 1'b1;
    repeat (4) @(posedge core_clk);
    read_check(OFS_DETECT, 32'h9c, "detect flag set");
    to_neg();
    check("reset request", sysRst, 1'b1);
    check("detect irq off", uvIrq, 1'b0);
    to_pos();
    bus_write(OFS_DETECT, 32'h7c);
    read_check(OFS_DETECT, 32'hbc, "ack while detecting");
    to_neg();
    check("detect irq on", uvIrq, 1'b1);
    to_pos();
    detectCmp <= 1'b0;
    repeat (4) @(posedge core_clk);
    bus_write(OFS_DETECT, 32'h7c);
    read_check(OFS_DETECT, 32'h3c, "flag acked");
    to_neg();
    check("irq after ack", {uvIrq, sysRst}, 2'b00);
    to_pos();
    // once bits are spent, so only the interrupt enable follows
    bus_write(OFS_DETECT, 32'h00);
    read_check(OFS_DETECT, 32'h1c, "once bits kept");
  endtask : t_detect

  task automatic t_irq();
    read_check(OFS_IRQ_STAT, 32'h1, "detect status");
    bus_write(OFS_IRQ_MASK, 32'h1);
    to_neg();
    check("irq unmasked", irq, 1'b1);
    to_pos();
    bus_write(OFS_IRQ_STAT, 32'h1);
    read_check(OFS_IRQ_STAT, 32'h0, "status cleared");
    to_neg();
    check("irq cleared", irq, 1'b0);
    to_pos();
  endtask : t_irq

  task automatic t_warning();
    bus_write(OFS_WARN, 32'h33);
    to_neg();
    check("detect select", detSel, 1'b1);
    check("warning select", warnSel, 1'b1);
    to_pos();
    warningCmp <= 1'b1;
    repeat (4) @(posedge core_clk);
    bus_write(OFS_WARN, 32'h70);
    read_check(OFS_WARN, 32'hb3, "warning held");
    warningCmp <= 1'b0;
    repeat (4) @(posedge core_clk);
    bus_write(OFS_WARN, 32'h30);
    read_check(OFS_WARN, 32'hb3, "ack of zero");
    bus_write(OFS_WARN, 32'h70);
    read_check(OFS_WARN, 32'h33, "warning acked");
  endtask : t_warning

  task automatic t_stop();
    do_stop(1'b0, 1'b1, 1'b1);
    read_check(OFS_WARN, 32'h3b, "recovery flag");
    bus_write(OFS_WARN, 32'h34);
    read_check(OFS_WARN, 32'h33, "recovery acked");
  endtask : t_stop

  task automatic t_resets();
    apply_reset(1'b0);
    read_check(OFS_WARN, 32'h30, "selects kept");
    read_check(OFS_DETECT, {24'h0, RST_DETECT_CTRL}, "detect reg again");
    apply_reset(1'b1);
    read_check(OFS_WARN, 32'h00, "selects cleared");
    do_stop(1'b0, 1'b0, 1'b1);
    bus_write(OFS_WARN, 32'h02);
    do_stop(1'b1, 1'b0, 1'b1);
    read_check(OFS_WARN, 32'h02, "no recovery after full");
  endtask : t_resets

  // detection held off in stop, then switched off altogether
  task automatic t_gating();
    bus_write(OFS_DETECT, 32'h34);
    read_check(OFS_DETECT, 32'h34, "stop enable off");
    do_stop(1'b1, 1'b0, 1'b0);
    apply_reset(1'b1);
    bus_write(OFS_DETECT, 32'h30);
    detectCmp <= 1'b1;
    repeat (4) @(posedge core_clk);
    read_check(OFS_DETECT, 32'h30, "detect disabled");
    to_neg();
    check("gated outputs", {detActive, uvIrq, sysRst}, 3'b000);
    to_pos();
    detectCmp <= 1'b0;
  endtask : t_gating

  initial begin
    apply_reset(1'b1);
    t_reset_values();
    t_detect();
    t_irq();
    t_warning();
    t_stop();
    t_resets();
    t_gating();
    conclude();
  end

  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    conclude();
  end
endmodule : testbench
